/* fbps_map.vh */
// Register map, field positions and timing counts for the flash protection block
`ifndef FBPS_MAP_VH
`define FBPS_MAP_VH
`define FBPS_ADDR_SECEN      12'h010
`define FBPS_ADDR_FLCS       12'h020
`define FBPS_ADDR_FLCMD      12'h030
`define FBPS_ADDR_STICKY     12'h034
`define FBPS_NBLK            10
`define FBPS_FLCS_BLK_LO     16
`define FBPS_FLCS_BLK_HI     25
`define FBPS_FLCS_RDY_BIT    0
`define FBPS_SEC_KEY         32'ha74a9d23
`define FBPS_KEY_WIN_CLKS    5'd16
`define FBPS_CLK_MHZ         200
`define FBPS_RDWAIT_US       2000
`define FBPS_RDWAIT_CYC      (`FBPS_RDWAIT_US * `FBPS_CLK_MHZ)
`define FBPS_OP_CYC          16'd64
`define FBPS_CMD_NONE        3'd0
`define FBPS_CMD_PROG        3'd1
`define FBPS_CMD_ERASE       3'd2
`define FBPS_CMD_PSET        3'd3
`define FBPS_CMD_PERASE      3'd4
`define FBPS_CMD_FAIL        3'd5
`endif

/* fbps_nv_store.v */
// Non-volatile model of the block protection flags
`timescale 1ns/1ps
`include "fbps_map.vh"
module fbps_nv_store (
   input  wire                     mclk_in,        // System clock
   input  wire                     set_in,         // Set flags in mask
   input  wire                     clr_all_in,     // Clear all flags
   input  wire                     clr_grp_in,     // Clear flags in mask
   input  wire [`FBPS_NBLK-1:0]    mask_in,        // Block mask
   output reg  [`FBPS_NBLK-1:0]    flags_out       // Stored flags
);
   // No reset: contents survive every reset, power-up content is all clear
   initial flags_out = {`FBPS_NBLK{1'b0}};
   always @(posedge mclk_in) begin
      if (clr_all_in)
         flags_out <= {`FBPS_NBLK{1'b0}};
      else if (clr_grp_in)
         flags_out <= flags_out & ~mask_in;
      else if (set_in)
         flags_out <= flags_out | mask_in;
   end
endmodule

/* fbps_op_timer.v */
// Down counter used for automatic operation time and read-back wait
`timescale 1ns/1ps
`include "fbps_map.vh"
module fbps_op_timer #(
   parameter integer W = 20                        // Counter width
) (
   input  wire          mclk_in,                   // System clock
   input  wire          resetn_in,                 // Sync reset, active low
   input  wire          load_in,                   // Load start value
   input  wire [W-1:0]  value_in,                  // Start value
   output wire          busy_out                   // Counting
);
   reg [W-1:0] cnt_r;
   // Counter counts down to zero after a load
   always @(posedge mclk_in) begin
      if (!resetn_in)
         cnt_r <= {W{1'b0}};
      else if (load_in)
         cnt_r <= value_in;
      else if (cnt_r != {W{1'b0}})
         cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
   end
   assign busy_out = (cnt_r != {W{1'b0}});
endmodule

/* fbps_top.v */
// Flash block protection and security control with APB register slave
//
// Notes on behaviour
// - Each block has a protection flag; protected blocks refuse program and erase.
// - Setting a block's protection to one protects; zero removes protection.
// - Clearing a block's protection flag by protection erase makes it writable and erasable.
// - Flags read back in status bits 25..16, one means protected.
// - Data writes into a protected block are rejected.
// - Security active only when enable bit and all ten flags are one.
// - Power-on reset forces the security enable bit to one.
// - CPU flash reads stay allowed while security is active.
// - Security blocks serial-wire debug and trace output.
// - Security rejects flash commands arriving on the debug path.
// - Protection erase under security clears all ten flags together.
// - Ready flag bit 0 is zero while busy, one when done.
// - A failed operation holds ready at zero until hardware reset.
// - After lock-out recovery, flash reads wait about 2 ms.
// - Security enable changes only after key then 32-bit write within 16 clocks.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "fbps_map.vh"
module fbps_top #(
   parameter integer RDWAIT_CYC = `FBPS_RDWAIT_CYC   // Read wait after lock-out
) (
   input  wire        mclk_in,          // 200 MHz system clock
   input  wire        resetn_in,        // System reset, sync, active low
   input  wire        por_n_in,         // Power-on reset, sync, active low
   input  wire        psel_in,          // APB select
   input  wire        penable_in,       // APB enable
   input  wire        pwrite_in,        // APB write
   input  wire [11:0] paddr_in,         // APB byte address
   input  wire [31:0] pwdata_in,        // APB write data
   input  wire [3:0]  pstrb_in,         // APB byte strobes
   output wire        pready_out,       // APB ready
   output reg  [31:0] prdata_out,       // APB read data
   output wire        pslverr_out,      // APB error
   input  wire        fcmd_valid_in,    // Flash command strobe
   input  wire [2:0]  fcmd_code_in,     // Flash command code
   input  wire [15:0] fcmd_addr_in,     // Command sequence bus address
   input  wire [3:0]  fcmd_blk_in,      // Target block index
   input  wire        fcmd_dbg_in,      // Command came from debug path
   output reg         fcmd_rej_out,     // Command rejected pulse
   input  wire        fwr_valid_in,     // Data write into flash strobe
   input  wire [3:0]  fwr_blk_in,       // Block of the data write
   output reg         fwr_rej_out,      // Data write rejected pulse
   input  wire        frd_req_in,       // CPU flash read request
   output wire        frd_ok_out,       // CPU read allowed
   input  wire        swd_in,           // Debug data from probe pin
   output wire        swd_out,          // Debug data to core
   input  wire        trace_in,         // Trace from core
   output wire        trace_out,        // Trace to pin
   output wire        secure_out        // Security state active
);
   localparam ST_IDLE = 2'd0;
   localparam ST_BUSY = 2'd1;
   localparam ST_LOCK = 2'd2;

   reg         sec_en_r;
   reg         por_seen_r;
   reg         key_ok_r;
   reg  [4:0]  key_cnt_r;
   reg  [1:0]  state_r;
   reg  [1:0]  state_nxt;
   reg  [2:0]  op_r;
   reg  [3:0]  op_blk_r;
   reg         lock_seen_r;
   reg         swd_m_r;
   reg         swd_s_r;
   wire [9:0]  blk_flags;
   wire        op_busy;
   wire        rd_wait;
   wire        secure;
   wire        apb_acc;
   wire        apb_wr;
   wire        addr_ok;
   wire        full_wr;
   wire [9:0]  cmd_mask;
   wire [9:0]  grp_mask;
   wire        cmd_addr_ok;
   wire        cmd_take;
   reg         nv_set;
   reg         nv_clr_all;
   reg         nv_clr_grp;
   reg  [9:0]  nv_mask;
   reg         op_load;

   // Security state from enable bit and every protection flag
   assign secure     = sec_en_r & (&blk_flags);
   assign secure_out = secure;

   // APB decode; zero wait state slave
   assign apb_acc     = psel_in & penable_in;
   assign apb_wr      = apb_acc & pwrite_in;
   assign addr_ok     = (paddr_in == `FBPS_ADDR_SECEN) | (paddr_in == `FBPS_ADDR_FLCS);
   assign pready_out  = 1'b1;
   assign pslverr_out = apb_acc & ~addr_ok;
   assign full_wr     = (pstrb_in == 4'hf);

   // Security enable: set at power-on, changed only by key then 32-bit write.
   // A system reset leaves the bit alone, only power-on forces it.
   always @(posedge mclk_in) begin
      if (!por_n_in) begin
         sec_en_r  <= 1'b1;
         key_ok_r  <= 1'b0;
         key_cnt_r <= 5'd0;
      end else if (!resetn_in) begin
         key_ok_r  <= 1'b0;
         key_cnt_r <= 5'd0;
      end else if (apb_wr && paddr_in == `FBPS_ADDR_SECEN && full_wr) begin
         if (pwdata_in == `FBPS_SEC_KEY) begin
            key_ok_r  <= 1'b1;
            key_cnt_r <= `FBPS_KEY_WIN_CLKS;
         end else if (key_ok_r) begin
            sec_en_r <= pwdata_in[0];
            key_ok_r <= 1'b0;
         end
      end else if (key_ok_r) begin
         // Window closes after sixteen clocks
         key_cnt_r <= key_cnt_r - 5'd1;
         if (key_cnt_r == 5'd1)
            key_ok_r <= 1'b0;
      end
   end

   // Track power-on so storage is not touched by a partly reset design
   always @(posedge mclk_in) begin
      if (!por_n_in)
         por_seen_r <= 1'b0;
      else
         por_seen_r <= 1'b1;
   end

   // Register read mux, reserved bits read zero
   always @* begin
      prdata_out = 32'h0;
      if (apb_acc && !pwrite_in) begin
         if (paddr_in == `FBPS_ADDR_SECEN)
            prdata_out = {31'h0, sec_en_r};
         else if (paddr_in == `FBPS_ADDR_FLCS) begin
            prdata_out[`FBPS_FLCS_BLK_HI:`FBPS_FLCS_BLK_LO] = blk_flags;
            prdata_out[`FBPS_FLCS_RDY_BIT] = (state_r == ST_IDLE);
         end
      end
   end

   // Per-block mask for the addressed block and its erase group
   assign cmd_mask = (fcmd_blk_in < 4'd10) ? (10'h001 << fcmd_blk_in) : 10'h000;
   assign grp_mask = (fcmd_blk_in < 4'd4) ? 10'h00f :
                     (fcmd_blk_in < 4'd8) ? 10'h0f0 : 10'h300;
   assign cmd_addr_ok = (fcmd_addr_in[15:8] == 8'h54) | (fcmd_addr_in[15:8] == 8'h55);
   assign cmd_take = fcmd_valid_in & ~(secure & fcmd_dbg_in) & cmd_addr_ok;

   // Command state machine: idle, automatic operation, lock-out
   always @* begin
      state_nxt  = state_r;
      nv_set     = 1'b0;
      nv_clr_all = 1'b0;
      nv_clr_grp = 1'b0;
      nv_mask    = cmd_mask;
      op_load    = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (cmd_take && fcmd_code_in != `FBPS_CMD_NONE) begin
               if ((fcmd_code_in == `FBPS_CMD_PROG || fcmd_code_in == `FBPS_CMD_ERASE)
                   && (blk_flags & cmd_mask) != 10'h0) begin
                  state_nxt = ST_IDLE;
               end else begin
                  state_nxt = ST_BUSY;
                  op_load   = 1'b1;
               end
            end
         end
         ST_BUSY: begin
            if (fcmd_valid_in) begin
               state_nxt = ST_LOCK;
            end else if (op_r == `FBPS_CMD_FAIL) begin
               state_nxt = ST_LOCK;
            end else if (!op_busy) begin
               state_nxt = ST_IDLE;
               if (op_r == `FBPS_CMD_PSET) begin
                  nv_set = 1'b1;
               end else if (op_r == `FBPS_CMD_PERASE) begin
                  if (secure)
                     nv_clr_all = 1'b1;
                  else begin
                     nv_clr_grp = 1'b1;
                     nv_mask    = (op_blk_r < 4'd4) ? 10'h00f :
                                  (op_blk_r < 4'd8) ? 10'h0f0 : 10'h300;
                  end
               end
               if (op_r == `FBPS_CMD_PSET)
                  nv_mask = (op_blk_r < 4'd10) ? (10'h001 << op_blk_r) : 10'h000;
            end
         end
         ST_LOCK: begin
            state_nxt = ST_LOCK;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // State and latched command; only a system reset leaves lock-out
   always @(posedge mclk_in) begin
      if (!resetn_in) begin
         state_r  <= ST_IDLE;
         op_r     <= `FBPS_CMD_NONE;
         op_blk_r <= 4'd0;
      end else begin
         state_r <= state_nxt;
         if (op_load) begin
            op_r     <= fcmd_code_in;
            op_blk_r <= fcmd_blk_in;
         end
      end
   end

   // Remember lock-out across reset to start the read wait afterwards
   always @(posedge mclk_in) begin
      if (!por_n_in)
         lock_seen_r <= 1'b0;
      else if (state_r == ST_LOCK)
         lock_seen_r <= 1'b1;
      else if (resetn_in)
         lock_seen_r <= 1'b0;
   end

   // Reject pulses for commands and for data writes
   always @(posedge mclk_in) begin
      if (!resetn_in) begin
         fcmd_rej_out <= 1'b0;
         fwr_rej_out  <= 1'b0;
      end else begin
         fcmd_rej_out <= fcmd_valid_in & (~cmd_take | (state_r != ST_IDLE) |
                         (((fcmd_code_in == `FBPS_CMD_PROG) |
                           (fcmd_code_in == `FBPS_CMD_ERASE)) &
                          ((blk_flags & cmd_mask) != 10'h0)));
         fwr_rej_out  <= fwr_valid_in & (fwr_blk_in < 4'd10) &
                         blk_flags[fwr_blk_in];
      end
   end

   // CPU reads allowed under security, held off during lock-out and during read wait
   assign frd_ok_out = frd_req_in & ~rd_wait & (state_r != ST_LOCK);

   // Debug pin synchroniser; gated afterwards so no logic sees stage one
   always @(posedge mclk_in) begin
      if (!resetn_in) begin
         swd_m_r <= 1'b0;
         swd_s_r <= 1'b0;
      end else begin
         swd_m_r <= swd_in;
         swd_s_r <= swd_m_r;
      end
   end
   assign swd_out   = swd_s_r & ~secure;
   assign trace_out = trace_in & ~secure;

   // Protection flags in storage that no reset touches
   fbps_nv_store u_store (
      .mclk_in    (mclk_in),
      .set_in     (nv_set & por_seen_r),
      .clr_all_in (nv_clr_all & por_seen_r),
      .clr_grp_in (nv_clr_grp & por_seen_r),
      .mask_in    (nv_mask),
      .flags_out  (blk_flags)
   );

   // Automatic operation duration
   fbps_op_timer #(.W(20)) u_op (
      .mclk_in   (mclk_in),
      .resetn_in (resetn_in),
      .load_in   (op_load),
      .value_in  ({4'h0, `FBPS_OP_CYC}),
      .busy_out  (op_busy)
   );

   // Read wait after leaving lock-out by reset
   fbps_op_timer #(.W(20)) u_rdwait (
      .mclk_in   (mclk_in),
      .resetn_in (por_n_in),
      .load_in   (lock_seen_r & ~resetn_in),
      .value_in  (RDWAIT_CYC[19:0]),
      .busy_out  (rd_wait)
   );
endmodule

/* fbps_top_sva.sv */
// Port checks for the flash protection block
`timescale 1ns/1ps
`include "fbps_map.vh"
module fbps_top_sva (
   input wire        mclk_in,       // Clock
   input wire        resetn_in,     // Sync reset
   input wire        psel_in,       // APB select
   input wire        penable_in,    // APB enable
   input wire        pwrite_in,     // APB write
   input wire [11:0] paddr_in,      // APB address
   input wire        pready_out,    // APB ready
   input wire [31:0] prdata_out,    // APB read data
   input wire        pslverr_out,   // APB error
   input wire        fcmd_valid_in, // Command strobe
   input wire        fcmd_dbg_in,   // Debug path
   input wire        fcmd_rej_out,  // Command reject
   input wire        fwr_rej_out,   // Write reject
   input wire        swd_out,       // Debug data out
   input wire        trace_in,      // Trace in
   input wire        trace_out,     // Trace out
   input wire        secure_out     // Security state
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   // Access decode; offsets beyond the map must be refused
   wire acc    = psel_in && penable_in;
   wire rd_fl  = acc && !pwrite_in && paddr_in == `FBPS_ADDR_FLCS;
   wire rd_sec = acc && !pwrite_in && paddr_in == `FBPS_ADDR_SECEN;
   wire mapped = paddr_in == `FBPS_ADDR_SECEN || paddr_in == `FBPS_ADDR_FLCS;
   a_trace_blocked: assert property (secure_out |-> !trace_out)
      else $error("trace leaks while secure");
   // Probe data is gated after its two-flop sync; the check still waits for three secure cycles
   a_swd_blocked: assert property (secure_out [*3] |-> !swd_out)
      else $error("debug data leaks while secure");
   a_trace_passes: assert property (!secure_out |-> trace_out == trace_in)
      else $error("trace not passed when open");
   a_dbg_cmd_rej: assert property (fcmd_valid_in && fcmd_dbg_in && secure_out |=> fcmd_rej_out)
      else $error("debug command not rejected");
   a_flcs_spare_zero: assert property (rd_fl |-> prdata_out[31:26] == 6'h00 && prdata_out[15:1] == 15'h0000)
      else $error("status spare bits not zero");
   a_secure_needs_all: assert property (rd_fl && prdata_out[25:16] != 10'h3ff |-> !secure_out)
      else $error("secure with a flag clear");
   a_secen_spare_zero: assert property (rd_sec |-> prdata_out[31:1] == 31'h0)
      else $error("enable spare bits not zero");
   a_apb_answer: assert property (acc |-> pready_out && pslverr_out == !mapped)
      else $error("wrong bus answer");
   c_secure: cover property ($rose(secure_out));
   c_cmd_rej: cover property (fcmd_rej_out);
   c_wr_rej: cover property (fwr_rej_out);
endmodule

/* fbps_far_model.sv */
// Far side: CPU command issuer and debug probe
`timescale 1ns/1ps
module fbps_far_model (
   input  wire        mclk_in,        // Clock
   input  wire        go_in,          // Issue one command
   input  wire [2:0]  code_in,        // Command code
   input  wire [3:0]  blk_in,         // Target block
   input  wire        dbg_in,         // Use debug path
   output reg         fcmd_valid_out, // Command strobe
   output reg  [2:0]  fcmd_code_out,  // Command code
   output reg  [15:0] fcmd_addr_out,  // Sequence address
   output reg  [3:0]  fcmd_blk_out,   // Block
   output reg         fcmd_dbg_out,   // Debug flag
   output reg         swd_out,        // Probe data pin
   output reg         trace_out       // Core trace
);
   reg seq_r;
   initial begin
      {fcmd_valid_out, fcmd_code_out, fcmd_addr_out, fcmd_blk_out} = 24'h0;
      {fcmd_dbg_out, swd_out, trace_out, seq_r} = 4'h0;
   end
   // Bench pulses go only while ready shows; idle lines churn, not hold
   always @(posedge mclk_in) begin
      fcmd_valid_out <= go_in;
      fcmd_code_out  <= go_in ? code_in : ~fcmd_code_out;
      fcmd_blk_out   <= go_in ? blk_in : ~fcmd_blk_out;
      fcmd_dbg_out   <= go_in ? dbg_in : ~fcmd_dbg_out;
      fcmd_addr_out  <= go_in ? (seq_r ? 16'h5500 : 16'h5400) : ~fcmd_addr_out;
      seq_r          <= seq_r ^ go_in;
      swd_out        <= ~swd_out;
      trace_out      <= swd_out ^ seq_r;
   end
endmodule

/* fbps_top_test.sv */
// Self-checking bench for the flash protection block
`timescale 1ns/1ps
`include "fbps_map.vh"
module fbps_top_test;
   localparam integer RDW = 50;
   reg         mclk_in = 1'b0, resetn_in = 1'b0, por_n_in = 1'b0;
   reg         psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   reg  [11:0] paddr_in = 12'h000;
   reg  [31:0] pwdata_in = 32'h0;
   reg  [3:0]  pstrb_in = 4'h0, fwr_blk_in = 4'h0, blk = 4'h0;
   reg         fwr_valid_in = 1'b0, frd_req_in = 1'b0, go = 1'b0, dbg = 1'b0;
   reg  [2:0]  code = 3'h0;
   wire        pready_out, pslverr_out, fcmd_valid_in, fcmd_dbg_in, fcmd_rej_out;
   wire        fwr_rej_out, frd_ok_out, swd_in, swd_out, trace_in, trace_out, secure_out;
   wire [31:0] prdata_out;
   wire [2:0]  fcmd_code_in;
   wire [15:0] fcmd_addr_in;
   wire [3:0]  fcmd_blk_in;
   logic [31:0] rd;
   logic        er;
   integer      err_total = 0;
   integer      tests_run = 0;
   always #2.5 mclk_in = ~mclk_in;
   fbps_top #(.RDWAIT_CYC(RDW)) u_fbps_top (.mclk_in(mclk_in), .resetn_in(resetn_in),
      .por_n_in(por_n_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
      .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .pready_out(pready_out),
      .prdata_out(prdata_out), .pslverr_out(pslverr_out), .fcmd_valid_in(fcmd_valid_in),
      .fcmd_code_in(fcmd_code_in), .fcmd_addr_in(fcmd_addr_in), .fcmd_blk_in(fcmd_blk_in),
      .fcmd_dbg_in(fcmd_dbg_in), .fcmd_rej_out(fcmd_rej_out), .fwr_valid_in(fwr_valid_in),
      .fwr_blk_in(fwr_blk_in), .fwr_rej_out(fwr_rej_out), .frd_req_in(frd_req_in),
      .frd_ok_out(frd_ok_out), .swd_in(swd_in), .swd_out(swd_out), .trace_in(trace_in),
      .trace_out(trace_out), .secure_out(secure_out));
   fbps_far_model u_fbps_far_model (.mclk_in(mclk_in), .go_in(go), .code_in(code),
      .blk_in(blk), .dbg_in(dbg), .fcmd_valid_out(fcmd_valid_in), .fcmd_code_out(fcmd_code_in),
      .fcmd_addr_out(fcmd_addr_in), .fcmd_blk_out(fcmd_blk_in), .fcmd_dbg_out(fcmd_dbg_in),
      .swd_out(swd_in), .trace_out(trace_in));
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task summarize;
      if (err_total == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One APB transfer; read data is taken at the edge that sees pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      integer n;
      @(posedge mclk_in);
      {psel_in, pwrite_in, paddr_in, pwdata_in, pstrb_in} <= {1'b1, w, a, d, s};
      @(posedge mclk_in);
      penable_in <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk_in);
         n = n + 1;
      end while (pready_out !== 1'b1 && n < 20);
      if (n >= 20) begin
         check("pready wait", 32'h0, 32'h1);
         summarize;
      end
      rd = prdata_out;
      er = pslverr_out;
      {psel_in, penable_in} <= 2'b00;
   endtask
   task rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0, 4'h0);
      check(nm, rd, e);
   endtask
   task sec_wr(input logic [31:0] v, input logic [3:0] s);
      apb(1'b1, `FBPS_ADDR_SECEN, `FBPS_SEC_KEY, 4'hf);
      apb(1'b1, `FBPS_ADDR_SECEN, v, s);
   endtask
   // Command via the far model; reject pulse lands one cycle after it is taken
   task cmd(input logic [2:0] c, input logic [3:0] b, input logic d, input logic rej);
      @(posedge mclk_in);
      {go, code, blk, dbg} <= {1'b1, c, b, d};
      @(posedge mclk_in);
      go <= 1'b0;
      @(posedge mclk_in);
      #1 check("cmd reject", {31'h0, fcmd_rej_out}, {31'h0, rej});
   endtask
   task fwr(input logic [3:0] b, input logic rej);
      @(posedge mclk_in);
      {fwr_valid_in, fwr_blk_in} <= {1'b1, b};
      @(posedge mclk_in);
      fwr_valid_in <= 1'b0;
      #1 check("write reject", {31'h0, fwr_rej_out}, {31'h0, rej});
   endtask
   task wait_ready;
      integer n;
      n = 0;
      rd = 32'h0;
      while (rd[0] !== 1'b1 && n < 100) begin
         apb(1'b0, `FBPS_ADDR_FLCS, 32'h0, 4'h0);
         n = n + 1;
      end
      if (n >= 100) begin
         check("ready wait", 32'h0, 32'h1);
         summarize;
      end
   endtask
   task s_regs;
      rchk(`FBPS_ADDR_SECEN, 32'h1, "secen reset");
      rchk(`FBPS_ADDR_FLCS, 32'h1, "status reset");
      apb(1'b1, `FBPS_ADDR_FLCS, 32'hffffffff, 4'hf);
      rchk(`FBPS_ADDR_FLCS, 32'h1, "status read only");
      apb(1'b0, 12'h024, 32'h0, 4'h0);
      check("unmapped error", {31'h0, er}, 32'h1);
   endtask
   // Enable bit moves only after the key and a full-word write soon after
   task s_key;
      apb(1'b1, `FBPS_ADDR_SECEN, 32'h0, 4'hf);
      rchk(`FBPS_ADDR_SECEN, 32'h1, "no key");
      sec_wr(32'h0, 4'h3);
      rchk(`FBPS_ADDR_SECEN, 32'h1, "part strobe");
      apb(1'b1, `FBPS_ADDR_SECEN, `FBPS_SEC_KEY, 4'hf);
      repeat (20) @(posedge mclk_in);
      apb(1'b1, `FBPS_ADDR_SECEN, 32'h0, 4'hf);
      rchk(`FBPS_ADDR_SECEN, 32'h1, "late write");
      sec_wr(32'h0, 4'hf);
      rchk(`FBPS_ADDR_SECEN, 32'h0, "keyed clear");
      sec_wr(32'h1, 4'hf);
      rchk(`FBPS_ADDR_SECEN, 32'h1, "keyed set");
   endtask
   task s_prot;
      integer b;
      logic [9:0] f;
      f = 10'h000;
      for (b = 0; b < 10; b = b + 1) begin
         fwr(b[3:0], 1'b0);
         check("secure early", {31'h0, secure_out}, 32'h0);
         cmd(`FBPS_CMD_PSET, b[3:0], 1'b0, 1'b0);
         apb(1'b0, `FBPS_ADDR_FLCS, 32'h0, 4'h0);
         check("busy", {31'h0, rd[0]}, 32'h0);
         wait_ready;
         f[b] = 1'b1;
         check("flags", rd, {6'h00, f, 16'h0001});
         fwr(b[3:0], 1'b1);
         cmd(`FBPS_CMD_PROG, b[3:0], 1'b0, 1'b1);
         cmd(`FBPS_CMD_ERASE, b[3:0], 1'b0, 1'b1);
      end
      check("secure on", {31'h0, secure_out}, 32'h1);
   endtask
   task s_secure;
      frd_req_in <= 1'b1;
      @(posedge mclk_in);
      #1 check("cpu read", {31'h0, frd_ok_out}, 32'h1);
      check("trace gated", {31'h0, trace_out}, 32'h0);
      cmd(`FBPS_CMD_PSET, 4'h0, 1'b1, 1'b1);
      cmd(`FBPS_CMD_PERASE, 4'h3, 1'b0, 1'b0);
      wait_ready;
      check("all cleared", rd, 32'h1);
      check("secure off", {31'h0, secure_out}, 32'h0);
      fwr(4'h0, 1'b0);
      cmd(`FBPS_CMD_PROG, 4'h0, 1'b0, 1'b0);
      wait_ready;
      // Outside security a protection erase clears only the block's group
      cmd(`FBPS_CMD_PSET, 4'h0, 1'b0, 1'b0);
      wait_ready;
      sec_wr(32'h0, 4'hf);
      cmd(`FBPS_CMD_PERASE, 4'h2, 1'b0, 1'b0);
      wait_ready;
      check("group cleared", rd, 32'h1);
      sec_wr(32'h1, 4'hf);
   endtask
   // Reset held 8 cycles stands in for the long lock-out reset to keep the run short
   task s_lock;
      cmd(`FBPS_CMD_FAIL, 4'h0, 1'b0, 1'b0);
      repeat (100) @(posedge mclk_in);
      rchk(`FBPS_ADDR_FLCS, 32'h0, "stuck busy");
      resetn_in <= 1'b0;
      repeat (8) @(posedge mclk_in);
      resetn_in <= 1'b1;
      repeat (5) @(posedge mclk_in);
      #1 check("read wait", {31'h0, frd_ok_out}, 32'h0);
      repeat (RDW) @(posedge mclk_in);
      #1 check("read back", {31'h0, frd_ok_out}, 32'h1);
      rchk(`FBPS_ADDR_FLCS, 32'h1, "ready after reset");
   endtask
   initial begin
      repeat (8) @(posedge mclk_in);
      {resetn_in, por_n_in} <= 2'b11;
      s_regs;
      s_key;
      s_prot;
      s_secure;
      s_lock;
      summarize;
   end
endmodule
bind fbps_top fbps_top_sva u_fbps_top_sva (.mclk_in(mclk_in), .resetn_in(resetn_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
   .fcmd_valid_in(fcmd_valid_in), .fcmd_dbg_in(fcmd_dbg_in), .fcmd_rej_out(fcmd_rej_out),
   .fwr_rej_out(fwr_rej_out), .swd_out(swd_out), .trace_in(trace_in),
   .trace_out(trace_out), .secure_out(secure_out));
